// ==== bench/lpmc_core_model.sv ====
// core side model: instruction pulses, wake levels and the interrupt mask flag
`timescale 1ns/10ps
module lpmc_core_model
  import lpmc_pkg::*;
(
  input  wire logic  core_clk_in,
  input  wire logic  srst_in,
  input  wire logic  do_wait_in,
  input  wire logic  do_stop_in,
  input  lpmc_wake_t wake_req_in,
  input  lpmc_event_t event_in,
  output logic       wait_exec_out,
  output logic       stop_exec_out,
  output lpmc_wake_t wake_out,
  output logic       imask_out
);
  // ----------------------------------------
  // instruction and request pass-through
  // ----------------------------------------
  // the bench paces these on falling edges, so they are stable at the sampling edge
  assign wait_exec_out = do_wait_in;
  assign stop_exec_out = do_stop_in;
  assign wake_out      = wake_req_in;

  // ----------------------------------------
  // interrupt mask flag of the core
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst_in || event_in.int_mask_set) begin
      imask_out <= 1'b1;
    end else if (event_in.int_mask_clr) begin
      imask_out <= 1'b0;
    end
  end
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the low-power mode controller
`timescale 1ns/10ps
module tb_top;
  import lpmc_pkg::*;
  logic         core_clk_in, srst_in, do_wait, do_stop, pin_n, supply_low;
  logic         wait_x, stop_x, imask;
  lpmc_cfg_t    cfg;
  lpmc_wake_t   wreq, wk;
  lpmc_mode_t   mode;
  lpmc_clk_t    ck;
  lpmc_periph_t pc;
  lpmc_event_t  ev;
  int           bad_count, num_checks, cyc;

  lpmc_top uut (.core_clk_in(core_clk_in), .srst_in(srst_in), .wait_exec_in(wait_x),
    .stop_exec_in(stop_x), .ext_reset_pin_n_in(pin_n), .supply_low_in(supply_low),
    .cfg_in(cfg), .wake_in(wk), .mode_out(mode), .clk_ctrl_out(ck),
    .periph_ctrl_out(pc), .event_out(ev));
  lpmc_core_model core (.core_clk_in(core_clk_in), .srst_in(srst_in), .do_wait_in(do_wait),
    .do_stop_in(do_stop), .wake_req_in(wreq), .event_in(ev), .wait_exec_out(wait_x),
    .stop_exec_out(stop_x), .wake_out(wk), .imask_out(imask));

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  // longest path is one full 4096-cycle recovery plus short tests
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      results();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_mode(input lpmc_mode_t exp);
    num_checks++;
    if (mode !== exp) begin
      bad_count++;
      $display("ERROR %0t mode got %0d exp %0d", $time, mode, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  // one-cycle instruction pulse; returns on the cycle after it was taken
  task automatic issue(input logic w, input logic s);
    do_wait = w;
    do_stop = s;
    tick(1);
    do_wait = 1'b0;
    do_stop = 1'b0;
  endtask
  task automatic leave(input lpmc_mode_t m);
    int i;
    for (i = 0; i < 10 && mode === m; i++) tick(1);
    chk_bit(mode !== m, 1'b1, "mode left in time");
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    srst_in = 1'b1;
    do_wait = 1'b0;
    do_stop = 1'b0;
    pin_n = 1'b1;
    supply_low = 1'b0;
    cfg = '0;
    wreq = '0;
    bad_count = 0;
    num_checks = 0;
    cyc = 0;
    repeat (16) @(posedge core_clk_in);
    @(negedge core_clk_in);
    srst_in = 1'b0;
    cfg.break_enable = 1'b1;
    cfg.ext_int_mask = 1'b1;
    tick(1);
    chk_mode(LPMC_RUN);
    chk_bit(ck.core, 1'b1, "core after reset");
    // wait: core off, bus and generator on, masked ext request ignored
    issue(1'b1, 1'b0);
    chk_mode(LPMC_WAIT);
    chk_bit(ck.core, 1'b0, "core in wait");
    chk_bit(ck.bus, 1'b1, "bus in wait");
    chk_bit(ck.osc & ck.gen_out, 1'b1, "generator in wait");
    chk_bit(ck.wdg, 1'b1, "watchdog clock in wait");
    chk_bit(pc.timebase_run & pc.timebase_locked, 1'b1, "timebase in wait");
    chk_bit(pc.break_active, 1'b1, "break in wait");
    chk_bit(pc.serial_freeze | pc.spi_freeze | pc.timer_freeze, 1'b0, "no freeze");
    chk_bit(ev.int_mask_clr, 1'b1, "mask clear pulse");
    wreq.ext_irq = 1'b1;
    tick(2);
    chk_mode(LPMC_WAIT);
    wreq.ext_irq = 1'b0;
    wreq.serial_irq = 1'b1;
    tick(1);
    chk_mode(LPMC_RUN);
    chk_bit(imask, 1'b0, "mask stays clear");
    wreq.serial_irq = 1'b0;
    // stop refused while disabled
    issue(1'b0, 1'b1);
    chk_mode(LPMC_RUN);
    chk_bit(ev.int_mask_clr, 1'b0, "no clear on refused stop");
    // stop with oscillator off, short recovery, keypad masked then ext unmasked
    cfg.stop_enable = 1'b1;
    cfg.short_stop_recovery = 1'b1;
    cfg.keypad_int_mask = 1'b1;
    issue(1'b0, 1'b1);
    chk_mode(LPMC_STOP);
    chk_bit(ck.core | ck.bus, 1'b0, "core and bus in stop");
    chk_bit(ck.osc | ck.pll | ck.osc_out | ck.gen_out | ck.gen_int, 1'b0, "gen off");
    chk_bit(ck.wdg, 1'b0, "watchdog clock cut");
    chk_bit(ev.wdg_prescale_clr, 1'b1, "prescaler clear");
    chk_bit(ev.conv_abort, 1'b1, "conversion abort");
    chk_bit(pc.conv_active, 1'b0, "converter idle");
    chk_bit(pc.serial_freeze, 1'b1, "serial frozen");
    chk_bit(pc.spi_freeze, 1'b1, "spi frozen");
    chk_bit(pc.timer_freeze, 1'b1, "timer frozen");
    chk_bit(pc.break_active, 1'b0, "break idle");
    wreq.keypad_irq = 1'b1;
    tick(2);
    chk_mode(LPMC_STOP);
    cfg.ext_int_mask = 1'b0;
    wreq.ext_irq = 1'b1;
    tick(1);
    chk_mode(LPMC_RECOVER);
    wreq = '0;
    tick(32);
    chk_mode(LPMC_RECOVER);
    chk_bit(ck.core, 1'b0, "core held");
    tick(1);
    chk_mode(LPMC_RUN);
    chk_bit(ck.core, 1'b1, "core restarted");
    chk_bit(ev.conv_settle, 1'b1, "settle pulse");
    chk_bit(pc.timer_freeze | pc.spi_freeze | pc.serial_freeze, 1'b0, "resumed");
    chk_bit(imask, 1'b0, "mask clear after irq exit");
    // stop with oscillator kept, left by supply-monitor reset, full recovery
    cfg.oscillator_run_in_stop = 1'b1;
    cfg.bus_clock_in_stop_enable = 1'b1;
    cfg.short_stop_recovery = 1'b0;
    cfg.supply_monitor_enable = 1'b1;
    cfg.supply_reset_enable = 1'b1;
    issue(1'b0, 1'b1);
    chk_bit(ck.osc & ck.bus, 1'b1, "osc and bus kept");
    chk_bit(ck.pll, 1'b0, "pll off");
    supply_low = 1'b1;
    leave(LPMC_STOP);
    chk_mode(LPMC_RECOVER);
    chk_bit(ev.spi_reset, 1'b1, "spi reset on reset exit");
    chk_bit(ev.int_mask_set, 1'b1, "mask set on reset exit");
    supply_low = 1'b0;
    tick(4096);
    chk_mode(LPMC_RECOVER);
    tick(1);
    chk_mode(LPMC_RUN);
    chk_bit(ev.conv_settle, 1'b0, "no settle after reset");
    chk_bit(imask, 1'b1, "mask set");
    // watchdog timeout in wait resets the device
    cfg.watchdog_enable = 1'b1;
    issue(1'b1, 1'b0);
    wreq.watchdog_timeout = 1'b1;
    tick(1);
    chk_mode(LPMC_RUN);
    chk_bit(ev.int_mask_set, 1'b1, "mask set on watchdog");
    tick(1);
    chk_bit(ev.sys_reset, 1'b1, "system reset");
    chk_bit(imask, 1'b1, "mask set after watchdog exit");
    wreq = '0;
    tick(4);
    chk_bit(ev.sys_reset, 1'b0, "reset released");
    // wait with pll engaged: keypad then timer requests wake it
    cfg.pll_power_bit = 1'b1;
    cfg.clock_source_select = 1'b1;
    cfg.keypad_int_mask = 1'b0;
    issue(1'b1, 1'b0);
    chk_bit(ck.pll & ck.pll_sel & ck.gen_int, 1'b1, "pll kept in wait");
    wreq.keypad_irq = 1'b1;
    tick(1);
    chk_mode(LPMC_RUN);
    wreq = '0;
    issue(1'b1, 1'b0);
    wreq.timer_irq = 1'b1;
    tick(1);
    chk_mode(LPMC_RUN);
    wreq = '0;
    // reset pin in wait: two sync edges, then the reset exit sets the mask
    issue(1'b1, 1'b0);
    pin_n = 1'b0;
    tick(2);
    chk_mode(LPMC_WAIT);
    tick(1);
    chk_mode(LPMC_RUN);
    chk_bit(ev.sys_reset & ev.int_mask_set, 1'b1, "pin reset exit");
    pin_n = 1'b1;
    tick(1);
    chk_bit(imask, 1'b1, "mask set after pin reset");
    results();
  end
endmodule

// ==== rtl/lpmc_defs.svh ====
// constants for the low-power mode controller
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH

// ----------------------------------------
// mode encodings (gray along run, stop, recover)
// ----------------------------------------
`define LPMC_MODE_RUN     2'h0
`define LPMC_MODE_STOP    2'h1
`define LPMC_MODE_RECOVER 2'h3
`define LPMC_MODE_WAIT    2'h2

// ----------------------------------------
// stop recovery counts, in oscillator cycles
// ----------------------------------------
`define LPMC_REC_W        13
`define LPMC_REC_LONG     13'h1000
`define LPMC_REC_SHORT    13'h0020
`define LPMC_REC_ZERO     13'h0000
`define LPMC_REC_ONE      13'h0001

`endif

// ==== rtl/lpmc_pkg.sv ====
// types for the low-power mode controller
package lpmc_pkg;
  `include "lpmc_defs.svh"

  typedef enum logic [1:0] {
    LPMC_RUN     = `LPMC_MODE_RUN,
    LPMC_STOP    = `LPMC_MODE_STOP,
    LPMC_RECOVER = `LPMC_MODE_RECOVER,
    LPMC_WAIT    = `LPMC_MODE_WAIT
  } lpmc_mode_t;

  typedef struct packed {
    logic bus_clock_in_stop_enable;
    logic oscillator_run_in_stop;
    logic stop_enable;
    logic short_stop_recovery;
    logic clock_source_select;
    logic pll_power_bit;
    logic ext_int_mask;
    logic keypad_int_mask;
    logic watchdog_enable;
    logic supply_monitor_enable;
    logic supply_reset_enable;
    logic break_enable;
  } lpmc_cfg_t;

  typedef struct packed {
    logic ext_irq;
    logic keypad_irq;
    logic serial_irq;
    logic spi_irq;
    logic timer_irq;
    logic converter_irq;
    logic timebase_irq;
    logic generator_irq;
    logic break_irq;
    logic watchdog_timeout;
  } lpmc_wake_t;

  typedef struct packed {
    logic core;
    logic bus;
    logic osc;
    logic pll;
    logic pll_sel;
    logic osc_out;
    logic gen_out;
    logic gen_int;
    logic wdg;
  } lpmc_clk_t;

  typedef struct packed {
    logic serial_freeze;
    logic spi_freeze;
    logic timer_freeze;
    logic break_active;
    logic timebase_run;
    logic timebase_locked;
    logic conv_active;
  } lpmc_periph_t;

  typedef struct packed {
    logic int_mask_clr;
    logic int_mask_set;
    logic conv_abort;
    logic conv_settle;
    logic wdg_prescale_clr;
    logic spi_reset;
    logic sys_reset;
  } lpmc_event_t;

  typedef struct packed {
    lpmc_mode_t   mode;
    logic         from_reset;
    logic         rst_s1;
    logic         rst_s2;
    logic         low_s1;
    logic         low_s2;
    lpmc_clk_t    clk;
    lpmc_periph_t periph;
    lpmc_event_t  ev;
  } lpmc_state_t;

  typedef struct packed {
    logic [`LPMC_REC_W-1:0] cnt;
  } lpmc_rec_state_t;
endpackage

// ==== rtl/lpmc_recovery_counter.sv ====
// stop recovery counter holding off the system clocks
`timescale 1ns/10ps
module lpmc_recovery_counter
  import lpmc_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic srst_in,
  input  wire logic load_in,
  input  wire logic short_in,
  output logic      done_out
);
  lpmc_rec_state_t s_q;
  lpmc_rec_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (load_in) begin
      s_d.cnt = short_in ? `LPMC_REC_SHORT : `LPMC_REC_LONG;
    end else if (s_q.cnt != `LPMC_REC_ZERO) begin
      s_d.cnt = s_q.cnt - `LPMC_REC_ONE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_out = (s_q.cnt == `LPMC_REC_ZERO);
endmodule

// ==== rtl/lpmc_top.sv ====
// low-power mode controller: run, wait and stop sequencing
`timescale 1ns/10ps
module lpmc_top
  import lpmc_pkg::*;
(
  input  wire logic   core_clk_in,
  input  wire logic   srst_in,
  input  wire logic   wait_exec_in,
  input  wire logic   stop_exec_in,
  input  wire logic   ext_reset_pin_n_in,
  input  wire logic   supply_low_in,
  input  lpmc_cfg_t   cfg_in,
  input  lpmc_wake_t  wake_in,
  output lpmc_mode_t  mode_out,
  output lpmc_clk_t   clk_ctrl_out,
  output lpmc_periph_t periph_ctrl_out,
  output lpmc_event_t event_out
);
  // ----------------------------------------
  // state and recovery counter
  // ----------------------------------------
  lpmc_state_t s_q;
  lpmc_state_t s_d;
  logic        reset_any;
  logic        ext_wake;
  logic        stop_wake;
  logic        wait_wake;
  logic        rec_load;
  logic        rec_done;
  logic        run_like;

  lpmc_recovery_counter u_rec (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .load_in     (rec_load),
    .short_in    (cfg_in.short_stop_recovery),
    .done_out    (rec_done)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.ev    = '0;
    rec_load  = 1'b0;
    // pin and comparator levels come from outside the clock domain
    s_d.rst_s1 = ~ext_reset_pin_n_in;
    s_d.rst_s2 = s_q.rst_s1;
    s_d.low_s1 = supply_low_in;
    s_d.low_s2 = s_q.low_s1;
    // watchdog can only time out while its clock runs
    reset_any = s_q.rst_s2
              | (cfg_in.supply_monitor_enable & cfg_in.supply_reset_enable
                 & s_q.low_s2)
              | (cfg_in.watchdog_enable & wake_in.watchdog_timeout
                 & s_q.clk.wdg);
    ext_wake  = (wake_in.ext_irq & ~cfg_in.ext_int_mask)
              | (wake_in.keypad_irq & ~cfg_in.keypad_int_mask);
    // timebase wakes stop only if the oscillator keeps it counting
    stop_wake = ext_wake
              | (wake_in.timebase_irq & cfg_in.oscillator_run_in_stop);
    wait_wake = ext_wake | wake_in.serial_irq
              | wake_in.spi_irq | wake_in.timer_irq
              | wake_in.converter_irq | wake_in.timebase_irq
              | wake_in.generator_irq | wake_in.break_irq;
    s_d.ev.sys_reset = reset_any;
    case (s_q.mode)
      LPMC_RUN: begin
        if (reset_any) begin
          s_d.mode = LPMC_RUN;
        end else if (wait_exec_in) begin
          s_d.mode            = LPMC_WAIT;
          s_d.ev.int_mask_clr = 1'b1;
        end else if (stop_exec_in && cfg_in.stop_enable) begin
          s_d.mode                = LPMC_STOP;
          s_d.ev.int_mask_clr     = 1'b1;
          s_d.ev.conv_abort       = 1'b1;
          s_d.ev.wdg_prescale_clr = 1'b1;
        end
      end
      LPMC_WAIT: begin
        if (reset_any) begin
          s_d.mode            = LPMC_RUN;
          s_d.ev.int_mask_set = 1'b1;
        end else if (wait_wake) begin
          s_d.mode = LPMC_RUN;
        end
      end
      LPMC_STOP: begin
        if (reset_any) begin
          s_d.mode            = LPMC_RECOVER;
          s_d.from_reset      = 1'b1;
          s_d.ev.int_mask_set = 1'b1;
          s_d.ev.spi_reset    = 1'b1;
          rec_load            = 1'b1;
        end else if (stop_wake) begin
          s_d.mode       = LPMC_RECOVER;
          s_d.from_reset = 1'b0;
          rec_load       = 1'b1;
        end
      end
      LPMC_RECOVER: begin
        // clocks stay inhibited until the oscillator has settled
        if (rec_done) begin
          s_d.mode           = LPMC_RUN;
          s_d.ev.conv_settle = ~s_q.from_reset;
        end
      end
      default: begin
        s_d.mode = LPMC_RUN;
      end
    endcase
    // clock gating follows the next mode so outputs stay registered
    run_like          = (s_d.mode == LPMC_RUN) || (s_d.mode == LPMC_WAIT);
    s_d.clk.core      = (s_d.mode == LPMC_RUN);
    s_d.clk.osc       = run_like || (s_d.mode == LPMC_RECOVER)
                      || cfg_in.oscillator_run_in_stop;
    s_d.clk.bus       = run_like
                      || ((s_d.mode == LPMC_STOP)
                          && cfg_in.bus_clock_in_stop_enable
                          && cfg_in.oscillator_run_in_stop);
    s_d.clk.pll       = run_like && cfg_in.pll_power_bit;
    s_d.clk.pll_sel   = s_d.clk.pll && cfg_in.clock_source_select;
    s_d.clk.osc_out   = s_d.clk.osc;
    s_d.clk.gen_out   = s_d.clk.bus;
    s_d.clk.gen_int   = s_d.clk.pll;
    s_d.clk.wdg       = run_like;
    // peripherals freeze rather than reset, so their registers survive
    s_d.periph.serial_freeze    = ~run_like;
    s_d.periph.spi_freeze       = ~run_like;
    s_d.periph.timer_freeze     = ~run_like;
    s_d.periph.break_active     = run_like && cfg_in.break_enable;
    s_d.periph.timebase_run     = run_like
                                || ((s_d.mode == LPMC_STOP)
                                    && cfg_in.oscillator_run_in_stop);
    s_d.periph.timebase_locked  = (s_d.mode != LPMC_RUN);
    s_d.periph.conv_active      = run_like;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s_q                     <= '0;
      s_q.mode                <= LPMC_RUN;
      s_q.clk.core            <= 1'b1;
      s_q.clk.bus             <= 1'b1;
      s_q.clk.osc             <= 1'b1;
      s_q.clk.osc_out         <= 1'b1;
      s_q.clk.gen_out         <= 1'b1;
      s_q.clk.wdg             <= 1'b1;
      s_q.periph.timebase_run <= 1'b1;
      s_q.periph.conv_active  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign mode_out        = s_q.mode;
  assign clk_ctrl_out    = s_q.clk;
  assign periph_ctrl_out = s_q.periph;
  assign event_out       = s_q.ev;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  core_off_wait_a: assert property (
    (s_q.mode == LPMC_WAIT) |-> (!s_q.clk.core && s_q.clk.bus))
    else $error("core clock or bus clock wrong in wait");

  bus_off_stop_a: assert property (
    ((s_q.mode == LPMC_STOP) && !$past(cfg_in.bus_clock_in_stop_enable))
      |-> (!s_q.clk.bus && !s_q.clk.core))
    else $error("bus clock runs in stop without enable");

  conv_abort_a: assert property (
    $rose(s_q.mode == LPMC_STOP) |-> (s_q.ev.conv_abort && !s_q.periph.conv_active))
    else $error("converter not aborted on stop entry");

  mask_clear_a: assert property (
    ((s_q.mode == LPMC_RUN) && !reset_any && wait_exec_in)
      |=> (s_q.ev.int_mask_clr && (s_q.mode == LPMC_WAIT)))
    else $error("wait entry did not clear interrupt mask");

  short_recover_a: assert property (
    ($rose(s_q.mode == LPMC_RECOVER) && $past(cfg_in.short_stop_recovery))
      |-> (!s_q.clk.core && (s_q.mode == LPMC_RECOVER)) ##32
          (s_q.mode == LPMC_RECOVER) ##1 (s_q.mode == LPMC_RUN && s_q.clk.core))
    else $error("short stop recovery length wrong");

  recover_hold_a: assert property (
    (s_q.mode == LPMC_RECOVER) |-> !s_q.clk.core)
    else $error("core clock runs during recovery");

  osc_off_stop_a: assert property (
    ((s_q.mode == LPMC_STOP) && !$past(cfg_in.oscillator_run_in_stop))
      |-> !(s_q.clk.osc || s_q.clk.osc_out || s_q.clk.gen_out || s_q.clk.gen_int))
    else $error("generator output active with oscillator off in stop");

  pll_off_stop_a: assert property (
    ((s_q.mode == LPMC_STOP) && $past(cfg_in.oscillator_run_in_stop))
      |-> (s_q.clk.osc && !s_q.clk.pll))
    else $error("pll or oscillator wrong in stop");

  watchdog_stop_a: assert property (
    $rose(s_q.mode == LPMC_STOP) |-> (s_q.ev.wdg_prescale_clr && !s_q.clk.wdg))
    else $error("watchdog not halted on stop entry");

  stop_gated_a: assert property (
    ((s_q.mode == LPMC_RUN) && stop_exec_in && !wait_exec_in
      && !cfg_in.stop_enable) |=> (s_q.mode == LPMC_RUN))
    else $error("stop entered while disabled");

  ext_wake_a: assert property (
    ((s_q.mode == LPMC_STOP) && !reset_any && wake_in.ext_irq
      && !cfg_in.ext_int_mask) |=> (s_q.mode == LPMC_RECOVER && !s_q.from_reset))
    else $error("external interrupt did not wake stop");

  serial_wake_a: assert property (
    ((s_q.mode == LPMC_WAIT) && wake_in.serial_irq) |=> (s_q.mode == LPMC_RUN))
    else $error("serial interrupt did not wake wait");

  freeze_stop_a: assert property (
    (s_q.mode == LPMC_STOP) |-> (s_q.periph.serial_freeze
      && s_q.periph.spi_freeze && s_q.periph.timer_freeze
      && !s_q.periph.break_active))
    else $error("peripheral not frozen in stop");

  timebase_block_a: assert property (
    (s_q.mode == LPMC_WAIT) |-> (s_q.periph.timebase_run && s_q.periph.timebase_locked))
    else $error("timebase state wrong in wait");

  pll_wait_a: assert property (
    ((s_q.mode == LPMC_WAIT) && $past(cfg_in.pll_power_bit))
      |-> (s_q.clk.osc && s_q.clk.pll))
    else $error("clock generator idle in wait");

  wdg_wait_a: assert property (
    ((s_q.mode == LPMC_WAIT) && cfg_in.watchdog_enable && wake_in.watchdog_timeout)
      |=> ((s_q.mode == LPMC_RUN) && s_q.ev.sys_reset))
    else $error("watchdog timeout did not reset wait");

  keypad_wake_a: assert property (
    ((s_q.mode == LPMC_WAIT) && wake_in.keypad_irq && !cfg_in.keypad_int_mask)
      |=> (s_q.mode == LPMC_RUN))
    else $error("keypad request did not wake wait");

  supply_reset_a: assert property (
    ((s_q.mode == LPMC_STOP) && s_q.low_s2 && cfg_in.supply_monitor_enable
      && cfg_in.supply_reset_enable) |=> ((s_q.mode == LPMC_RECOVER) && s_q.from_reset))
    else $error("supply monitor did not reset stop");

  spi_reset_a: assert property (
    ((s_q.mode == LPMC_STOP) && reset_any) |=> (s_q.ev.spi_reset && s_q.ev.int_mask_set))
    else $error("reset exit from stop did not reset spi");

  timer_resume_a: assert property (
    ((s_q.mode == LPMC_RECOVER) && rec_done) |=> (!s_q.periph.timer_freeze
      && !s_q.periph.spi_freeze && !s_q.periph.serial_freeze && s_q.clk.core))
    else $error("peripherals still frozen after stop exit");

  timer_wake_a: assert property (
    ((s_q.mode == LPMC_WAIT) && (wake_in.timer_irq || wake_in.spi_irq))
      |=> (s_q.mode == LPMC_RUN))
    else $error("timer or spi request did not wake wait");

  break_mode_a: assert property (
    (s_q.mode == LPMC_WAIT) |-> (s_q.periph.break_active == $past(cfg_in.break_enable)))
    else $error("break unit state wrong in wait");

  recover_wait_a: assert property (
    ((s_q.mode == LPMC_RECOVER) && !rec_done) |=> (s_q.mode == LPMC_RECOVER))
    else $error("recovery left before counter expired");

  pin_reset_a: assert property (
    s_q.rst_s2 |=> s_q.ev.sys_reset)
    else $error("reset pin did not raise system reset");

  wait_exit_c: cover property (
    (s_q.mode == LPMC_WAIT) ##1 (s_q.mode == LPMC_RUN));
  stop_exit_c: cover property (
    (s_q.mode == LPMC_RECOVER) ##1 (s_q.mode == LPMC_RUN) && s_q.ev.conv_settle);
  reset_exit_c: cover property (
    (s_q.mode == LPMC_STOP) ##1 s_q.ev.spi_reset);
  pin_reset_c: cover property (
    (s_q.mode == LPMC_WAIT) ##1 s_q.ev.int_mask_set);
endmodule
